// file: inc/lcd_drv_pkg.sv
// Shared constants of the three-phase segment LCD driver: load layout,
// frame timing, register offsets, field positions and reset values.
// Assumes a 200 MHz reference clock and a 32-bit APB register bus.
`default_nettype none
package lcd_drv_pkg;

   // Load layout: display bits first, then the three control bits.
   localparam int DISP_BITS = 96;
   localparam int CTRL_BITS = 3;
   localparam int LOAD_BITS = DISP_BITS + CTRL_BITS;
   localparam int LOAD_BLANK_POS = 2;
   localparam int LOAD_SLEEP_POS = 1;
   localparam int LOAD_BIAS_POS  = 0;

   // Panel geometry.
   localparam int SEG_N = 32;
   localparam int COM_N = 3;

   // Frame timing in oscillator periods.
   localparam int FRAME_OSC_PERIODS = 384;
   localparam int PHASE_OSC_PERIODS = FRAME_OSC_PERIODS / COM_N;
   localparam int TICK_W            = 7;
   localparam int PHASE_W           = 2;
   localparam logic [TICK_W-1:0]  TICK_LAST   = TICK_W'(PHASE_OSC_PERIODS - 1);
   localparam logic [PHASE_W-1:0] PHASE_FIRST = 2'h0;
   localparam logic [PHASE_W-1:0] PHASE_MID   = 2'h1;
   localparam logic [PHASE_W-1:0] PHASE_LAST  = 2'h2;

   // Oscillator emulation: reference cycles per oscillator period.
   localparam int REF_CLK_HZ      = 200_000_000;
   localparam int OSC_FREQ_HZ     = 38_000;
   localparam int OSC_DIV_DEFAULT = REF_CLK_HZ / OSC_FREQ_HZ;
   localparam int OSC_DIV_W       = 16;

   // Register offsets (byte addresses).
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_DISP0   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_DISP1   = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_DISP2   = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_CTRL    = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_OSC_DIV = 8'h14;

   // Field positions.
   localparam int CTRL_BLANK_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam int CTRL_BIAS_BIT  = 2;
   localparam int STAT_SEL_BIT   = 0;
   localparam int STAT_PHASE_LSB = 4;
   localparam int STAT_CNT_LSB   = 8;
   localparam int STAT_CNT_W     = 8;

   // Reset values.
   localparam logic [DISP_BITS-1:0] DISP_RESET = '0;
   localparam logic                 CTRL_RESET = 1'b0;

endpackage
`default_nettype wire

// file: core/shift_link.sv
// Serial shift register on the host's shift clock.
// Assumes frame select and serial input are launched by the host with setup
// and hold to the rising shift clock edge, and that the clock idles between loads.
`timescale 1ns/10ps
`default_nettype none
module shift_link #(
   parameter int LOAD_W = lcd_drv_pkg::LOAD_BITS
) (
   // Link clock and reset.
   input  wire logic              shift_clk,
   input  wire logic              link_rst,
   // Serial pins.
   input  wire logic              frame_sel,
   input  wire logic              serial_in,
   // Shifted word toward the reference domain.
   output logic [LOAD_W-1:0]      shift_word
);

   typedef struct packed {
      logic [LOAD_W-1:0] sr;
   } link_state_t;

   link_state_t q;
   link_state_t d;

   generate
      if (LOAD_W < 2) begin : g_bad_width
         $error("shift_link needs at least two bits");
      end
   endgenerate

   // Shift only inside a frame; outside it edges leave the word untouched.
   always_comb begin
      d = q;
      if (frame_sel) begin
         d.sr = {q.sr[LOAD_W-2:0], serial_in};
      end
   end

   // The word is reset by the system reset and by the clear pin.
   always_ff @(posedge shift_clk or posedge link_rst) begin
      if (link_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign shift_word = q.sr;

endmodule
`default_nettype wire

// file: core/frame_seq.sv
// Oscillator emulation and backplane phase sequencer.
// Assumes a divider value supplied from the register file and a run level that
// is low while the panel sleeps.
`timescale 1ns/10ps
`default_nettype none
module frame_seq #(
   parameter int DIV_W = lcd_drv_pkg::OSC_DIV_W
) (
   // Clock and reset.
   input  wire logic                               clk,
   input  wire logic                               rst,
   // Control.
   input  wire logic                               run,
   input  wire logic [DIV_W-1:0]                   div_value,
   // Current backplane phase, 0 drives the first backplane.
   output logic [lcd_drv_pkg::PHASE_W-1:0]         phase
);

   typedef struct packed {
      logic [DIV_W-1:0]                  pre;
      logic [lcd_drv_pkg::TICK_W-1:0]    tick;
      logic [lcd_drv_pkg::PHASE_W-1:0]   phase;
   } seq_state_t;

   seq_state_t q;
   seq_state_t d;

   generate
      if (lcd_drv_pkg::PHASE_OSC_PERIODS * lcd_drv_pkg::COM_N != lcd_drv_pkg::FRAME_OSC_PERIODS) begin : g_bad_frame
         $error("frame length must split evenly over the backplanes");
      end
      if (lcd_drv_pkg::PHASE_OSC_PERIODS > (1 << lcd_drv_pkg::TICK_W)) begin : g_bad_tick
         $error("tick counter too narrow for one phase");
      end
   endgenerate

   // A divider value of zero behaves as one so the oscillator never stalls.
   always_comb begin
      d = q;
      if (run) begin
         if (({1'b0, q.pre} + 1'b1) >= {1'b0, div_value}) begin
            d.pre = '0;
            if (q.tick == lcd_drv_pkg::TICK_LAST) begin
               d.tick = '0;
               if (q.phase == lcd_drv_pkg::PHASE_LAST) begin
                  d.phase = lcd_drv_pkg::PHASE_FIRST;
               end else begin
                  d.phase = q.phase + 1'b1;
               end
            end else begin
               d.tick = q.tick + 1'b1;
            end
         end else begin
            d.pre = q.pre + 1'b1;
         end
      end
   end

   // Counters hold their place while stopped and resume from it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign phase = q.phase;

endmodule
`default_nettype wire

// file: core/lcd_segment_serial_driver.sv
// Top of the 96-segment, three-backplane LCD driver: serial load, latches,
// frame sequencing, segment drive and the APB register file.
// Assumes the host drives the three-wire load on its own shift clock and that
// analog bias generation sits outside, steered by the bias select output.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - A low level on the clear pin empties every display and control latch.
// - Serial bits are accepted only while frame select is high, which the host holds for the whole load.
// - Each rising shift clock edge moves the serial input level into the shift register.
// - Active display and control latches keep their old contents until frame select falls, then take the new word.
// - With blanking set the segments show all display bits as zero while the oscillator keeps running.
// - With sleep set the oscillator stops and all segment and backplane outputs are low.
// - Bias select chooses one-third drive when 0 and one-half drive when 1.
// - Segment n shows bit 3n-2 in the third phase, bit 3n-1 in the second and bit 3n in the first.
// - The three phases together last 384 oscillator periods per frame.
// - Thirty-two segment outputs are multiplexed across the three backplanes.
module lcd_segment_serial_driver #(
   parameter int   OSC_DIV_INIT = lcd_drv_pkg::OSC_DIV_DEFAULT,
   parameter logic D1_FIRST     = 1'b1
) (
   // Reference clock and reset.
   input  wire logic                             REF_CLK,
   input  wire logic                             RST,
   // APB slave.
   input  wire logic                             PSEL,
   input  wire logic                             PENABLE,
   input  wire logic                             PWRITE,
   input  wire logic [lcd_drv_pkg::ADDR_W-1:0]   PADDR,
   input  wire logic [31:0]                      PWDATA,
   output logic      [31:0]                      PRDATA,
   output logic                                  PREADY,
   output logic                                  PSLVERR,
   // Serial load pins.
   input  wire logic                             SHIFT_CLOCK,
   input  wire logic                             FRAME_SEL,
   input  wire logic                             SERIAL_IN,
   input  wire logic                             CLEAR_ALL_N,
   // Panel drive.
   output logic      [lcd_drv_pkg::SEG_N-1:0]    SEGMENT_OUT,
   output logic      [lcd_drv_pkg::COM_N-1:0]    BACKPLANE_OUT,
   output logic                                  BIAS_SELECT,
   output logic                                  SLEEP_CTL
);

   localparam int DISP_W = lcd_drv_pkg::DISP_BITS;
   localparam int LOAD_W = lcd_drv_pkg::LOAD_BITS;
   localparam int SEG_W  = lcd_drv_pkg::SEG_N;
   localparam int COM_W  = lcd_drv_pkg::COM_N;
   localparam int DIV_W  = lcd_drv_pkg::OSC_DIV_W;
   localparam int CNT_W  = lcd_drv_pkg::STAT_CNT_W;

   typedef struct packed {
      logic                sel_s1;
      logic                sel_s2;
      logic                sel_s3;
      logic                clr_s1;
      logic                clr_s2;
      logic [DISP_W-1:0]   disp;
      logic                blank;
      logic                sleep;
      logic                bias;
      logic [DIV_W-1:0]    osc_div;
      logic [CNT_W-1:0]    load_cnt;
      logic [31:0]         prdata;
      logic                pslverr;
      logic [SEG_W-1:0]    seg;
      logic [COM_W-1:0]    com;
      logic                bias_out;
      logic                sleep_out;
   } top_state_t;

   top_state_t q;
   top_state_t d;

   logic [LOAD_W-1:0]                shift_word;
   logic [DISP_W-1:0]                load_disp;
   logic [SEG_W-1:0]                 seg_now;
   logic [lcd_drv_pkg::PHASE_W-1:0]  phase;
   logic                             link_rst;
   logic                             sel_fall;
   logic                             apb_setup;
   logic                             apb_write;

   generate
      if (OSC_DIV_INIT < 1 || OSC_DIV_INIT >= (1 << DIV_W)) begin : g_bad_div
         $error("OSC_DIV_INIT does not fit the divider register");
      end
      if (DISP_W != SEG_W * COM_W) begin : g_bad_geometry
         $error("display bits must match segments times backplanes");
      end
   endgenerate

   // The clear pin also resets the link side directly, since the shift clock
   // may be idle while it is low; a glitch on it can only clear, never corrupt.
   assign link_rst = RST | ~CLEAR_ALL_N;

   shift_link #(
      .LOAD_W     (LOAD_W)
   ) u_link (
      .shift_clk  (SHIFT_CLOCK),
      .link_rst   (link_rst),
      .frame_sel  (FRAME_SEL),
      .serial_in  (SERIAL_IN),
      .shift_word (shift_word)
   );

   frame_seq #(
      .DIV_W     (DIV_W)
   ) u_seq (
      .clk       (REF_CLK),
      .rst       (RST),
      .run       (~q.sleep),
      .div_value (q.osc_div),
      .phase     (phase)
   );

   // Pick the display bits out of the shifted word in the chosen order.
   genvar gi;
   generate
      for (gi = 0; gi < DISP_W; gi++) begin : g_order
         assign load_disp[gi] = D1_FIRST ? shift_word[LOAD_W-1-gi]
                                         : shift_word[lcd_drv_pkg::CTRL_BITS+gi];
      end
   endgenerate

   // Each segment takes the bit of its triple that belongs to the live phase.
   genvar gs;
   generate
      for (gs = 0; gs < SEG_W; gs++) begin : g_seg
         always_comb begin
            case (phase)
               lcd_drv_pkg::PHASE_FIRST: seg_now[gs] = q.disp[COM_W*gs+2];
               lcd_drv_pkg::PHASE_MID:   seg_now[gs] = q.disp[COM_W*gs+1];
               lcd_drv_pkg::PHASE_LAST:  seg_now[gs] = q.disp[COM_W*gs];
               default:                  seg_now[gs] = 1'b0;
            endcase
         end
      end
   endgenerate

   // The word is only read after the synchronised select has fallen, when the
   // host has stopped the shift clock, so it is stable across the crossing.
   assign sel_fall  = q.sel_s3 & ~q.sel_s2;
   assign apb_setup = PSEL & ~PENABLE;
   assign apb_write = PSEL & PENABLE & PWRITE;

   // Next state: synchronisers, latches, panel drive and register access.
   always_comb begin
      d = q;
      d.sel_s1 = FRAME_SEL;
      d.sel_s2 = q.sel_s1;
      d.sel_s3 = q.sel_s2;
      d.clr_s1 = CLEAR_ALL_N;
      d.clr_s2 = q.clr_s1;

      // Latches change only at the end of a load; a clear overrides a load.
      if (!q.clr_s2) begin
         d.disp  = lcd_drv_pkg::DISP_RESET;
         d.blank = lcd_drv_pkg::CTRL_RESET;
         d.sleep = lcd_drv_pkg::CTRL_RESET;
         d.bias  = lcd_drv_pkg::CTRL_RESET;
      end else if (sel_fall) begin
         d.disp     = load_disp;
         d.blank    = shift_word[lcd_drv_pkg::LOAD_BLANK_POS];
         d.sleep    = shift_word[lcd_drv_pkg::LOAD_SLEEP_POS];
         d.bias     = shift_word[lcd_drv_pkg::LOAD_BIAS_POS];
         d.load_cnt = q.load_cnt + 1'b1;
      end

      // Panel drive follows the latched controls.
      if (q.sleep) begin
         d.seg = '0;
         d.com = '0;
      end else begin
         d.com = COM_W'(1) << phase;
         d.seg = q.blank ? '0 : seg_now;
      end
      d.bias_out  = q.bias;
      d.sleep_out = q.sleep;

      // Register writes land at the access edge.
      if (apb_write && PADDR == lcd_drv_pkg::ADDR_OSC_DIV) begin
         d.osc_div = PWDATA[DIV_W-1:0];
      end

      // Read data and error are prepared in the setup cycle.
      if (apb_setup) begin
         d.prdata  = '0;
         d.pslverr = 1'b0;
         case (PADDR)
            lcd_drv_pkg::ADDR_DISP0: begin
               if (!PWRITE) begin
                  d.prdata = q.disp[31:0];
               end
            end
            lcd_drv_pkg::ADDR_DISP1: begin
               if (!PWRITE) begin
                  d.prdata = q.disp[63:32];
               end
            end
            lcd_drv_pkg::ADDR_DISP2: begin
               if (!PWRITE) begin
                  d.prdata = q.disp[95:64];
               end
            end
            lcd_drv_pkg::ADDR_CTRL: begin
               if (!PWRITE) begin
                  d.prdata[lcd_drv_pkg::CTRL_BLANK_BIT] = q.blank;
                  d.prdata[lcd_drv_pkg::CTRL_SLEEP_BIT] = q.sleep;
                  d.prdata[lcd_drv_pkg::CTRL_BIAS_BIT]  = q.bias;
               end
            end
            lcd_drv_pkg::ADDR_STATUS: begin
               if (!PWRITE) begin
                  d.prdata[lcd_drv_pkg::STAT_SEL_BIT] = q.sel_s2;
                  d.prdata[lcd_drv_pkg::STAT_PHASE_LSB +: lcd_drv_pkg::PHASE_W] = phase;
                  d.prdata[lcd_drv_pkg::STAT_CNT_LSB +: CNT_W] = q.load_cnt;
               end
            end
            lcd_drv_pkg::ADDR_OSC_DIV: begin
               if (!PWRITE) begin
                  d.prdata[DIV_W-1:0] = q.osc_div;
               end
            end
            default: begin
               d.pslverr = 1'b1;
            end
         endcase
      end
   end

   // One register stage for all state; only constants under reset.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         q         <= '0;
         q.osc_div <= DIV_W'(OSC_DIV_INIT);
      end else begin
         q <= d;
      end
   end

   // Zero-wait slave: the answer is ready in every access phase.
   assign PREADY        = 1'b1;
   assign PRDATA        = q.prdata;
   assign PSLVERR       = q.pslverr;
   assign SEGMENT_OUT   = q.seg;
   assign BACKPLANE_OUT = q.com;
   assign BIAS_SELECT   = q.bias_out;
   assign SLEEP_CTL     = q.sleep_out;

endmodule
`default_nettype wire

// file: bench/lcd_segment_serial_driver_monitor.sv
// Port-level checker for the LCD driver: panel drive timing and latch behaviour.
// Assumes it is bound to the top module with the same oscillator divider.
`timescale 1ns/10ps
`default_nettype none
module lcd_segment_serial_driver_monitor #(
   parameter int OSC_DIV_INIT = 2
) (
   // Clock, reset and bus.
   input wire logic                             REF_CLK,
   input wire logic                             RST,
   input wire logic                             PSEL,
   input wire logic                             PENABLE,
   input wire logic [lcd_drv_pkg::ADDR_W-1:0]   PADDR,
   input wire logic                             PSLVERR,
   // Load pins and panel drive.
   input wire logic                             FRAME_SEL,
   input wire logic                             CLEAR_ALL_N,
   input wire logic [lcd_drv_pkg::SEG_N-1:0]    SEGMENT_OUT,
   input wire logic [lcd_drv_pkg::COM_N-1:0]    BACKPLANE_OUT,
   input wire logic                             BIAS_SELECT,
   input wire logic                             SLEEP_CTL
);
   localparam int PH = lcd_drv_pkg::PHASE_OSC_PERIODS * OSC_DIV_INIT;
   logic [2:0]  bp_prev_q;
   logic [15:0] len_q;
   logic        full_q;
   logic        fs_q;
   logic [3:0]  quiet_q;
   // Exact phase length is judged only for phases entered by a clean rotation, as sleep cuts phases short.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         bp_prev_q <= 3'h0;
         len_q     <= 16'h0;
         full_q    <= 1'b0;
         fs_q      <= 1'b0;
         quiet_q   <= 4'hF;
      end else begin
         bp_prev_q <= BACKPLANE_OUT;
         fs_q      <= FRAME_SEL;
         if (BACKPLANE_OUT != bp_prev_q) begin
            len_q  <= 16'h0;
            full_q <= (bp_prev_q != 3'h0) && (BACKPLANE_OUT != 3'h0);
         end else begin
            len_q <= len_q + 16'h1;
         end
         if ((fs_q && !FRAME_SEL) || !CLEAR_ALL_N) begin
            quiet_q <= 4'h0;
         end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
         end
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   sequence sleep_held;
      SLEEP_CTL [*2];
   endsequence
   sequence awake_run;
      !SLEEP_CTL [*3];
   endsequence
   sequence turn;
      BACKPLANE_OUT != bp_prev_q && bp_prev_q != 3'h0 && BACKPLANE_OUT != 3'h0;
   endsequence
   sleep_low_a: assert property (sleep_held |-> BACKPLANE_OUT == 3'h0 && SEGMENT_OUT == '0)
      else $error("outputs not low while sleeping");
   bp_onehot_a: assert property (awake_run |-> $onehot(BACKPLANE_OUT))
      else $error("backplane drive not one-hot");
   bp_rotate_a: assert property (turn |-> BACKPLANE_OUT == {bp_prev_q[1:0], bp_prev_q[2]})
      else $error("backplane phase order wrong");
   phase_len_a: assert property (turn ##0 full_q |-> len_q == PH - 1)
      else $error("phase length wrong");
   phase_max_a: assert property (BACKPLANE_OUT != 3'h0 && BACKPLANE_OUT == bp_prev_q |-> len_q < PH - 1)
      else $error("phase lasts too long");
   clear_all_a: assert property (!CLEAR_ALL_N [*6] |-> !SLEEP_CTL && !BIAS_SELECT && SEGMENT_OUT == '0)
      else $error("clear did not empty latches");
   latch_hold_a: assert property ($changed(BIAS_SELECT) || $changed(SLEEP_CTL) |-> quiet_q < 4'hC)
      else $error("control latch changed without load end");
   bad_addr_a: assert property (PSEL && PENABLE && PADDR > 8'h14 |-> PSLVERR)
      else $error("unmapped access without error");
endmodule
bind lcd_segment_serial_driver lcd_segment_serial_driver_monitor #(.OSC_DIV_INIT(OSC_DIV_INIT)) u_mon (
   .REF_CLK, .RST, .PSEL, .PENABLE, .PADDR, .PSLVERR, .FRAME_SEL, .CLEAR_ALL_N,
   .SEGMENT_OUT, .BACKPLANE_OUT, .BIAS_SELECT, .SLEEP_CTL);
`default_nettype wire

// file: bench/lcd_host_model.sv
// Host side of the three-wire load: frame select, shift clock and data.
// Assumes the caller spaces loads; send runs its 80 ns shift clock only inside frames, noise runs it outside them.
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
   // Serial load pins toward the driver.
   output logic shift_clock,
   output logic frame_sel,
   output logic serial_in
);
   // Idle levels at time zero.
   initial begin
      shift_clock = 1'b0;
      frame_sel   = 1'b0;
      serial_in   = 1'b0;
   end
   // The odd start offset keeps link edges off the reference clock edges.
   task automatic send(input logic [98:0] bits);
      #1.3 frame_sel = 1'b1;
      #40;
      for (int i = 98; i >= 0; i--) begin
         serial_in = bits[i];
         #20 shift_clock = 1'b1;
         #40 shift_clock = 1'b0;
         #20;
      end
      #20 frame_sel = 1'b0;
      serial_in = ~serial_in;
      #100;
   endtask
   // Clock and data activity with frame select low, which must change nothing.
   task automatic noise;
      for (int i = 0; i < 8; i++) begin
         #20 serial_in = ~serial_in;
         shift_clock = 1'b1;
         #40 shift_clock = 1'b0;
      end
   endtask
   // A frame with no bits relatches whatever the shift register holds.
   task automatic pulse;
      #1.3 frame_sel = 1'b1;
      #100 frame_sel = 1'b0;
      #100;
   endtask
endmodule
`default_nettype wire

// file: bench/lcd_segment_serial_driver_tb_top.sv
// Self-checking bench for the LCD driver: APB master, host model, scenario tasks.
// Assumes the bound checker and a divider of 2 so a phase lasts 256 reference cycles.
`timescale 1ns/10ps
`default_nettype none
module lcd_segment_serial_driver_tb_top;
   localparam int          DIV = 2;
   localparam logic [95:0] PAT = 96'h0123456789ABCDEF_FEDCBA98;
   logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic        sck, fs, sdi, clear_n, bias_o, sleep_o, erv;
   logic [31:0] seg_o;
   logic [2:0]  bp_o;
   int          fails = 0;
   int          total_checks = 0;

   lcd_segment_serial_driver #(.OSC_DIV_INIT(DIV)) u_dut (
      .REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SHIFT_CLOCK(sck),
      .FRAME_SEL(fs), .SERIAL_IN(sdi), .CLEAR_ALL_N(clear_n), .SEGMENT_OUT(seg_o),
      .BACKPLANE_OUT(bp_o), .BIAS_SELECT(bias_o), .SLEEP_CTL(sleep_o));
   lcd_host_model u_host (.shift_clock(sck), .frame_sel(fs), .serial_in(sdi));

   // Reference clock, 5 ns period.
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; read data and error are taken at the edge that sees pready.
   // No answer time is assumed: a slave that never answers is left to the watchdog.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic regs(input logic [95:0] d, input logic [31:0] c);
      apb(1'b0, lcd_drv_pkg::ADDR_DISP0, 32'h0);
      chk(rdv, d[31:0]);
      apb(1'b0, lcd_drv_pkg::ADDR_DISP1, 32'h0);
      chk(rdv, d[63:32]);
      apb(1'b0, lcd_drv_pkg::ADDR_DISP2, 32'h0);
      chk(rdv, d[95:64]);
      apb(1'b0, lcd_drv_pkg::ADDR_CTRL, 32'h0);
      chk(rdv, c);
   endtask

   // Sends a load while confirming the old bias and sleep controls still stand 800 cycles into it, before frame select falls.
   task automatic load(input logic [95:0] d, input logic bl, input logic sl, input logic bi);
      logic [98:0] bits;
      logic        b0, s0;
      b0 = bias_o;
      s0 = sleep_o;
      for (int k = 0; k < 96; k++) bits[98-k] = d[k];
      bits[2:0] = {bl, sl, bi};
      fork
         u_host.send(bits);
         begin
            repeat (800) @(posedge ref_clk);
            chk(bias_o, b0);
            chk(sleep_o, s0);
         end
      join
      repeat (10) @(posedge ref_clk);
   endtask

   task automatic wait_bp;
      logic [2:0] b;
      int         n;
      b = bp_o;
      n = 0;
      while (bp_o === b && n < 4000) begin
         @(posedge ref_clk);
         n++;
      end
      repeat (2) @(posedge ref_clk);
      #1;
      chk(n < 4000, 1'b1);
   endtask

   function automatic logic [31:0] seg_exp(input logic [95:0] d, input logic [2:0] bp);
      int          p;
      logic [31:0] s;
      p = bp[0] ? 0 : (bp[1] ? 1 : 2);
      for (int n = 1; n <= 32; n++) s[n-1] = d[3*n-p-1];
      return s;
   endfunction

   task automatic t_regs;
      regs('0, 32'h0);
      apb(1'b1, lcd_drv_pkg::ADDR_OSC_DIV, 32'(DIV));
      apb(1'b0, lcd_drv_pkg::ADDR_OSC_DIV, 32'h0);
      chk(rdv, 32'(DIV));
      apb(1'b1, lcd_drv_pkg::ADDR_CTRL, 32'h7);
      apb(1'b0, lcd_drv_pkg::ADDR_CTRL, 32'h0);
      chk(rdv, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk(erv, 1'b1);
      chk(bp_o, 3'h1);
   endtask

   task automatic t_display;
      load(PAT, 1'b0, 1'b0, 1'b1);
      regs(PAT, 32'h4);
      chk(bias_o, 1'b1);
      repeat (3) begin
         wait_bp();
         chk(seg_o, seg_exp(PAT, bp_o));
      end
   endtask

   task automatic t_blank;
      load(PAT, 1'b1, 1'b0, 1'b0);
      chk(bias_o, 1'b0);
      repeat (2) begin
         wait_bp();
         chk(seg_o, 32'h0);
      end
   endtask

   // Sleep freezes the phase counter; waking resumes normal drive.
   task automatic t_sleep;
      logic [1:0] s;
      load(PAT, 1'b0, 1'b1, 1'b0);
      chk(sleep_o, 1'b1);
      apb(1'b0, lcd_drv_pkg::ADDR_STATUS, 32'h0);
      s = rdv[5:4];
      chk(rdv[15:8], 8'h03);
      repeat (600) @(posedge ref_clk);
      chk(bp_o, 3'h0);
      apb(1'b0, lcd_drv_pkg::ADDR_STATUS, 32'h0);
      chk(rdv[5:4], s);
      load(PAT, 1'b0, 1'b0, 1'b0);
      wait_bp();
      chk(seg_o, seg_exp(PAT, bp_o));
   endtask

   task automatic t_ignore;
      u_host.noise();
      u_host.pulse();
      repeat (10) @(posedge ref_clk);
      regs(PAT, 32'h0);
   endtask

   task automatic t_clear;
      load(PAT, 1'b0, 1'b0, 1'b1);
      @(posedge ref_clk);
      clear_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      clear_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk(bias_o, 1'b0);
      chk(seg_o, 32'h0);
      regs('0, 32'h0);
      // The clear also empties the shift register, so an empty frame now latches zeros.
      u_host.pulse();
      repeat (10) @(posedge ref_clk);
      regs('0, 32'h0);
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Main sequence: reset for 12 cycles, then the scenarios.
   initial begin
      rst     = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h0;
      pwdata  = 32'h0;
      clear_n = 1'b1;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      t_regs();
      t_display();
      t_blank();
      t_sleep();
      t_ignore();
      t_clear();
      summarize();
   end

   // Watchdog: the scenarios need about 11k cycles.
   initial begin
      #400_000;
      fails++;
      summarize();
   end
endmodule
`default_nettype wire
